// file: logic/nvsac_pkg.sv
// package for the nonvolatile shadow access control block
// assumes a 16-bit register port with 8-bit addresses
package nvsac_pkg;
    // register offsets
    localparam logic [7:0]  ADDR_UNLOCK      = 8'h31;
    localparam logic [7:0]  ADDR_READY       = 8'h32;
    localparam logic [7:0]  ADDR_TARGET      = 8'h33;
    localparam logic [7:0]  ADDR_WDATA       = 8'h34;
    localparam logic [7:0]  ADDR_ACCESS_CTRL = 8'h35;
    localparam logic [7:0]  ADDR_RDATA       = 8'h36;
    localparam logic [7:0]  ADDR_HOLE1_LO    = 8'h37;
    localparam logic [7:0]  ADDR_HOLE1_HI    = 8'h5F;
    localparam logic [7:0]  ADDR_INHIBIT     = 8'h60;
    localparam logic [7:0]  ADDR_HOLE2_LO    = 8'h61;
    localparam logic [7:0]  ADDR_HOLE2_HI    = 8'h8F;
    localparam logic [7:0]  ADDR_PROFILE1    = 8'h90;
    localparam logic [7:0]  ADDR_CUST_HI     = 8'h96;
    // field positions
    localparam int          POS_SHADOW       = 12;
    localparam int          POS_RELOAD       = 8;
    localparam int          POS_WNR          = 2;
    localparam int          POS_INHIBIT      = 15;
    // field masks of the access control register
    localparam logic [15:0] ACCESS_CTRL_MASK = 16'h1107;
    // reset values and key
    localparam logic [15:0] RESET_WORD       = 16'h0000;
    localparam logic [15:0] UNLOCK_KEY       = 16'hC0DE;
    // access modes
    localparam logic [1:0]  MODE_OFF         = 2'h0;
    localparam logic [1:0]  MODE_SINGLE      = 2'h1;
    localparam logic [1:0]  MODE_BULK        = 2'h2;
    // nonvolatile store timing
    localparam int          NV_ACCESS_NS     = 40;
    localparam int          CLK_PERIOD_NS    = 4;
    localparam int          NV_ACCESS_CYC    = (NV_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  NV_CYC_W         = 4'(NV_ACCESS_CYC);
    localparam int          NV_DEPTH         = 7;
endpackage : nvsac_pkg

// file: logic/nvsac_store.sv
// nonvolatile store model: array of customer words with an access timer
// assumes one request pulse at a time, issued only while ready
`timescale 1ns/100ps
module nvsac_store
(
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    input  wire logic        req_i,
    input  wire logic        write_i,
    input  wire logic [2:0]  index_i,
    input  wire logic [15:0] wdata_i,
    output logic             ready_o,
    output logic             done_o,
    output logic [15:0]      rdata_o
);
    import nvsac_pkg::*;

    logic [15:0] mem_q [NV_DEPTH];
    logic [15:0] mem_d [NV_DEPTH];
    logic [3:0]  cnt_q;
    logic [3:0]  cnt_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        done_d;
    logic        done_q;

    // timer, write and fetch
    always_comb
    begin
        mem_d   = mem_q;
        cnt_d   = cnt_q;
        rdata_d = rdata_q;
        done_d  = 1'b0;
        if (cnt_q != 4'h0)
        begin
            cnt_d = cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
                done_d = 1'b1;
            end
        end
        else if (req_i && (32'(index_i) < NV_DEPTH))
        begin
            cnt_d = NV_CYC_W;
            if (write_i)
            begin
                mem_d[index_i] = wdata_i;
            end
            else
            begin
                rdata_d = mem_q[index_i];
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            for (int i = 0; i < NV_DEPTH; i++)
            begin
                mem_q[i] <= RESET_WORD;
            end
            cnt_q   <= 4'h0;
            rdata_q <= RESET_WORD;
            done_q  <= 1'b0;
        end
        else
        begin
            mem_q   <= mem_d;
            cnt_q   <= cnt_d;
            rdata_q <= rdata_d;
            done_q  <= done_d;
        end
    end

    assign ready_o = (cnt_q == 4'h0);
    assign done_o  = done_q;
    assign rdata_o = rdata_q;
endmodule : nvsac_store

// file: logic/nvsac_top.sv
// register file for shadow select, reload and single-location access
// assumes a serial-bus front end giving one-cycle write and read strobes
`timescale 1ns/100ps

// Behaviour
// - With shadow select set the drive runs from shadow values, else the profile outputs are zero.
// - With shadow select set, a read of a configuration location returns the shadow contents.
// - Writing the reload bit copies the store into the shadow registers.
// - The direction bit picks a store read at 0 and a store write at 1.
// - Access select decodes 00 off, 01 single, 10 bulk, 11 reserved.
// - The read result register shows the word fetched by the last single read.
// - Addresses 0x37 to 0x5F hold no registers and read zero.
// - The drive inhibit bit at 15 of 0x60 is write-only and reads back zero.
// - Writing 1 to drive inhibit stops motor control, 0 enables it.
// - Addresses 0x61 to 0x8F hold no registers and read zero.
// - The first profile word at 0x90 resets to zero and holds the six drive fields.
// - The target register holds the 8-bit store location for single access.
// - The ready flag reads 1 while the store can take an access and no access sequence is running.
module nvsac_top
(
    input  wire logic        clock_i,
    input  wire logic        arst_n_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    output logic [15:0]      rdata_o,
    output logic             drive_inhibit_o,
    output logic             shadow_select_o,
    output logic [15:0]      profile_one_o,
    output logic [1:0]       spread_select_o,
    output logic [1:0]       tach_open_loop_select_o,
    output logic [3:0]       tach_divider_o,
    output logic             cycle_adjust_select_o,
    output logic [2:0]       resistance_shift_o,
    output logic [3:0]       resistance_value_o
);
    import nvsac_pkg::*;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic in_cust(input logic [7:0] a);
        in_cust = (a >= ADDR_PROFILE1) && (a <= ADDR_CUST_HI);
    endfunction : in_cust

    typedef enum logic [2:0]
    {
        NVSAC_IDLE   = 3'b001,
        NVSAC_SINGLE = 3'b010,
        NVSAC_BULK   = 3'b100
    } nvsac_state_e;

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [15:0]  unlock_word_q, unlock_word_d;
    logic [7:0]   single_target_location_q, single_target_location_d;
    logic [15:0]  single_write_word_q, single_write_word_d;
    logic [15:0]  access_ctrl_q, access_ctrl_d;
    logic [15:0]  single_read_word_q, single_read_word_d;
    logic         drive_inhibit_q, drive_inhibit_d;
    logic [15:0]  shadow_q [NV_DEPTH];
    logic [15:0]  shadow_d [NV_DEPTH];
    logic [2:0]   bulk_idx_q, bulk_idx_d;
    logic         pend_rd_q, pend_rd_d;
    logic [15:0]  rdata_q, rdata_d;
    nvsac_state_e state_q, state_d;

    logic         nv_req;
    logic         nv_write;
    logic [2:0]   nv_index;
    logic [15:0]  nv_wdata;
    logic         nv_ready_flag;
    logic         nv_done;
    logic [15:0]  nv_rdata;
    logic         key_ok;
    logic         shadow_select;
    logic [1:0]   nv_access_select;
    logic         nv_write_not_read;
    logic         access_wr;

    assign key_ok            = (unlock_word_q == UNLOCK_KEY);
    assign shadow_select     = access_ctrl_q[POS_SHADOW];
    assign nv_access_select  = access_ctrl_q[1:0];
    assign nv_write_not_read = access_ctrl_q[POS_WNR];
    assign access_wr         = wr_i && (addr_i == ADDR_ACCESS_CTRL);

    // store instance
    nvsac_store u_store
    (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .req_i    (nv_req),
        .write_i  (nv_write),
        .index_i  (nv_index),
        .wdata_i  (nv_wdata),
        .ready_o  (nv_ready_flag),
        .done_o   (nv_done),
        .rdata_o  (nv_rdata)
    );

    // -----------------------------------------------------------------
    // register writes and access sequencer
    // -----------------------------------------------------------------
    always_comb
    begin
        unlock_word_d            = unlock_word_q;
        single_target_location_d = single_target_location_q;
        single_write_word_d      = single_write_word_q;
        access_ctrl_d            = access_ctrl_q;
        single_read_word_d       = single_read_word_q;
        drive_inhibit_d          = drive_inhibit_q;
        shadow_d                 = shadow_q;
        bulk_idx_d               = bulk_idx_q;
        pend_rd_d                = pend_rd_q;
        state_d                  = state_q;
        nv_req                   = 1'b0;
        nv_write                 = 1'b0;
        nv_index                 = 3'(single_target_location_q - ADDR_PROFILE1);
        nv_wdata                 = single_write_word_q;
        if (wr_i)
        begin
            case (addr_i)
                ADDR_UNLOCK:      unlock_word_d = wdata_i;
                ADDR_TARGET:      single_target_location_d = wdata_i[7:0];
                ADDR_WDATA:       single_write_word_d = wdata_i;
                ADDR_ACCESS_CTRL: access_ctrl_d = wdata_i & ACCESS_CTRL_MASK;
                ADDR_INHIBIT:     drive_inhibit_d = wdata_i[POS_INHIBIT];
                default:
                begin
                    if (in_cust(addr_i) && key_ok)
                    begin
                        shadow_d[3'(addr_i - ADDR_PROFILE1)] = wdata_i;
                    end
                end
            endcase
        end
        case (state_q)
            NVSAC_IDLE:
            begin
                if (access_ctrl_q[POS_RELOAD] && nv_ready_flag)
                begin
                    access_ctrl_d[POS_RELOAD] = access_wr && wdata_i[POS_RELOAD];
                    bulk_idx_d = 3'h0;
                    pend_rd_d  = 1'b1; // reload always reads the store
                    state_d    = NVSAC_BULK;
                end
                else if (access_wr && wdata_i[POS_RELOAD])
                begin
                    state_d = NVSAC_IDLE;
                end
                else if ((nv_access_select == MODE_SINGLE) && nv_ready_flag && key_ok
                         && in_cust(single_target_location_q))
                begin
                    nv_req    = 1'b1;
                    nv_write  = nv_write_not_read;
                    pend_rd_d = !nv_write_not_read;
                    access_ctrl_d[1:0] = access_wr ? wdata_i[1:0] : MODE_OFF; // host write wins
                    state_d   = NVSAC_SINGLE;
                end
                else if ((nv_access_select == MODE_BULK) && nv_ready_flag && key_ok)
                begin
                    bulk_idx_d = 3'h0; // bulk: walk every shadow word
                    pend_rd_d  = !nv_write_not_read;
                    access_ctrl_d[1:0] = access_wr ? wdata_i[1:0] : MODE_OFF; // host write wins
                    state_d    = NVSAC_BULK;
                end
            end
            NVSAC_SINGLE:
            begin
                if (nv_done)
                begin
                    if (pend_rd_q)
                    begin
                        single_read_word_d = nv_rdata;
                    end
                    pend_rd_d = 1'b0;
                    state_d   = NVSAC_IDLE;
                end
            end
            NVSAC_BULK:
            begin
                nv_index = bulk_idx_q;
                nv_wdata = shadow_q[bulk_idx_q];
                nv_write = !pend_rd_q; // direction latched at start
                if (nv_ready_flag && !nv_done)
                begin
                    nv_req = 1'b1;
                end
                if (nv_done)
                begin
                    if (pend_rd_q)
                    begin
                        shadow_d[bulk_idx_q] = nv_rdata;
                    end
                    if (32'(bulk_idx_q) == NV_DEPTH - 1)
                    begin
                        pend_rd_d = 1'b0;
                        state_d = NVSAC_IDLE;
                    end
                    else
                    begin
                        bulk_idx_d = bulk_idx_q + 3'h1;
                    end
                end
            end
            default: state_d = NVSAC_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            unlock_word_q            <= RESET_WORD;
            single_target_location_q <= 8'h00;
            single_write_word_q      <= RESET_WORD;
            access_ctrl_q            <= RESET_WORD;
            single_read_word_q       <= RESET_WORD;
            drive_inhibit_q          <= 1'b0;
            for (int i = 0; i < NV_DEPTH; i++)
            begin
                shadow_q[i] <= RESET_WORD;
            end
            bulk_idx_q               <= 3'h0;
            pend_rd_q                <= 1'b0;
            state_q                  <= NVSAC_IDLE;
        end
        else
        begin
            unlock_word_q            <= unlock_word_d;
            single_target_location_q <= single_target_location_d;
            single_write_word_q      <= single_write_word_d;
            access_ctrl_q            <= access_ctrl_d;
            single_read_word_q       <= single_read_word_d;
            drive_inhibit_q          <= drive_inhibit_d;
            shadow_q                 <= shadow_d;
            bulk_idx_q               <= bulk_idx_d;
            pend_rd_q                <= pend_rd_d;
            state_q                  <= state_d;
        end
    end

    // -----------------------------------------------------------------
    // read mux
    // -----------------------------------------------------------------
    always_comb
    begin
        rdata_d = rdata_q;
        if (rd_i)
        begin
            case (addr_i)
                ADDR_UNLOCK:      rdata_d = unlock_word_q;
                ADDR_READY:       rdata_d = {15'h0000, nv_ready_flag && (state_q == NVSAC_IDLE)};
                ADDR_TARGET:      rdata_d = {8'h00, single_target_location_q};
                ADDR_WDATA:       rdata_d = single_write_word_q;
                ADDR_ACCESS_CTRL: rdata_d = access_ctrl_q;
                ADDR_RDATA:       rdata_d = single_read_word_q;
                ADDR_INHIBIT:     rdata_d = RESET_WORD;
                default:
                begin
                    rdata_d = RESET_WORD;
                    if (in_cust(addr_i))
                    begin
                        rdata_d = shadow_q[3'(addr_i - ADDR_PROFILE1)];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            rdata_q <= RESET_WORD;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign rdata_o                 = rdata_q;
    assign drive_inhibit_o         = drive_inhibit_q;
    assign shadow_select_o         = shadow_select;
    assign profile_one_o           = shadow_select ? shadow_q[0] : RESET_WORD;
    assign spread_select_o         = profile_one_o[15:14];
    assign tach_open_loop_select_o = profile_one_o[13:12];
    assign tach_divider_o          = profile_one_o[11:8];
    assign cycle_adjust_select_o   = profile_one_o[7];
    assign resistance_shift_o      = profile_one_o[6:4];
    assign resistance_value_o      = profile_one_o[3:0];

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    sequence s_single_start;
        state_q == NVSAC_IDLE && nv_req && nv_write;
    endsequence

    a_inhibit_set: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        wr_i && addr_i == ADDR_INHIBIT |=> drive_inhibit_o == $past(wdata_i[15]))
        else $error("drive inhibit not taken");
    a_inhibit_read: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        rd_i && addr_i == ADDR_INHIBIT |=> rdata_o == 16'h0000)
        else $error("inhibit readback not zero");
    a_hole_read: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        rd_i && addr_i >= ADDR_HOLE1_LO && addr_i <= ADDR_HOLE1_HI |=> rdata_o == 16'h0000)
        else $error("first hole not zero");
    a_hole2_read: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        rd_i && addr_i >= ADDR_HOLE2_LO && addr_i <= ADDR_HOLE2_HI |=> rdata_o == 16'h0000)
        else $error("second hole not zero");
    a_reserved_zero: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (access_ctrl_q & ~ACCESS_CTRL_MASK) == 16'h0000)
        else $error("reserved bits set");
    a_shadow_drive: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        !shadow_select |-> profile_one_o == 16'h0000)
        else $error("shadow used while off");
    a_write_busy: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        s_single_start |=> !nv_ready_flag [*8] ##1 !nv_ready_flag [*2] ##1 nv_ready_flag)
        else $error("write busy window wrong");
    a_read_result: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        state_q == NVSAC_SINGLE && nv_done && pend_rd_q |=> single_read_word_q == $past(nv_rdata))
        else $error("read result not captured");
    a_mode_off: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        state_q == NVSAC_IDLE && nv_access_select == MODE_OFF |-> !nv_req)
        else $error("access while disabled");
endmodule : nvsac_top

// file: tb/nvsac_host_model.sv
// host model driving the register port of the access control block
// assumes the block samples its strobes on the rising clock edge
`timescale 1ns/100ps
module nvsac_host_model
(
    input  wire logic        clock_i,
    output logic             wr_o,
    output logic             rd_o,
    output logic [7:0]       addr_o,
    output logic [15:0]      wdata_o,
    input  wire logic [15:0] rdata_i
);
    import nvsac_pkg::*;

    int gap_cycles = 0; // extra idle cycles per access, for a slow host

    // idle bus at time zero
    initial
    begin
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        addr_o  = 8'h00;
        wdata_o = 16'h0000;
    end

    // drop strobes, scramble released lines, then idle
    task automatic release_bus;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        addr_o  = ~addr_o;
        wdata_o = ~wdata_o;
        repeat (gap_cycles) @(negedge clock_i);
    endtask : release_bus

    // one write cycle, reserved control bits kept clear
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        logic [15:0] word;
        word = data;
        if (addr == ADDR_ACCESS_CTRL)
        begin
            word = data & ACCESS_CTRL_MASK;
        end
        @(negedge clock_i);
        wr_o    = 1'b1;
        addr_o  = addr;
        wdata_o = word;
        @(negedge clock_i);
        release_bus();
    endtask : write_reg

    // one read cycle, data taken once it has settled
    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
        @(negedge clock_i);
        rd_o   = 1'b1;
        addr_o = addr;
        @(negedge clock_i);
        release_bus();
        @(negedge clock_i);
        data = rdata_i;
    endtask : read_reg

    // key load before touching the customer words
    task automatic unlock;
        write_reg(ADDR_UNLOCK, UNLOCK_KEY);
    endtask : unlock

    // motor stop around store programming
    task automatic set_inhibit(input logic stop);
        write_reg(ADDR_INHIBIT, {stop, 15'h0000});
    endtask : set_inhibit
endmodule : nvsac_host_model

// file: tb/test_nvsac_top.sv
// self-checking bench for the access control register block
// assumes the host model owns the register port
`timescale 1ns/100ps
module test_nvsac_top;
    import nvsac_pkg::*;

    logic        clock_i;
    logic        arst_n_i;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        inhibit;
    logic        shadow;
    logic [15:0] profile;
    logic [1:0]  spread;
    logic [1:0]  tach_ol;
    logic [3:0]  tach_div;
    logic        cyc_adj;
    logic [2:0]  r_shift;
    logic [3:0]  r_value;
    int          num_errors = 0;
    int          n_checks = 0;
    logic [7:0]  holes [4] = '{8'h37, 8'h5F, 8'h61, 8'h8F};

    nvsac_top nvsac_top_i (.clock_i(clock_i), .arst_n_i(arst_n_i), .wr_i(wr), .rd_i(rd), .addr_i(addr),
        .wdata_i(wdata), .rdata_o(rdata), .drive_inhibit_o(inhibit), .shadow_select_o(shadow),
        .profile_one_o(profile), .spread_select_o(spread), .tach_open_loop_select_o(tach_ol),
        .tach_divider_o(tach_div), .cycle_adjust_select_o(cyc_adj), .resistance_shift_o(r_shift),
        .resistance_value_o(r_value));

    nvsac_host_model nvsac_host_model_i (.clock_i(clock_i), .wr_o(wr), .rd_o(rd), .addr_o(addr),
        .wdata_o(wdata), .rdata_i(rdata));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_sim;
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        nvsac_host_model_i.write_reg(a, d);
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        nvsac_host_model_i.read_reg(a, v);
        check(v, exp, $sformatf("read of %h", a));
    endtask : rd_chk

    // poll the ready flag with a bound
    task automatic wait_ready;
        logic [15:0] v;
        v = 16'h0000;
        for (int i = 0; i < 100 && v[0] !== 1'b1; i++)
            nvsac_host_model_i.read_reg(ADDR_READY, v);
        if (v[0] !== 1'b1)
        begin
            num_errors++;
            $display("[FAIL] %0t ready flag stuck low", $time);
            end_sim();
        end
    endtask : wait_ready

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset;
        check({inhibit, shadow, 14'h0000}, 16'h0000, "control outputs after reset");
        check(profile, RESET_WORD, "profile output after reset");
        rd_chk(ADDR_ACCESS_CTRL, 16'h0000);
        rd_chk(ADDR_RDATA, 16'h0000);
        rd_chk(ADDR_PROFILE1, RESET_WORD);
    endtask : test_reset

    task automatic test_holes;
        foreach (holes[i])
        begin
            wr_reg(holes[i], 16'hFFFF);
            rd_chk(holes[i], 16'h0000);
        end
    endtask : test_holes

    task automatic test_inhibit;
        nvsac_host_model_i.set_inhibit(1'b1);
        check({15'h0000, inhibit}, 16'h0001, "inhibit set");
        rd_chk(ADDR_INHIBIT, 16'h0000);
        nvsac_host_model_i.set_inhibit(1'b0);
        check({15'h0000, inhibit}, 16'h0000, "inhibit clear");
    endtask : test_inhibit

    task automatic test_profile;
        wr_reg(ADDR_PROFILE1, 16'hA5C3);
        rd_chk(ADDR_PROFILE1, 16'h0000);
        nvsac_host_model_i.unlock();
        wr_reg(ADDR_ACCESS_CTRL, 16'h1000);
        check({15'h0000, shadow}, 16'h0001, "shadow select");
        rd_chk(ADDR_ACCESS_CTRL, 16'h1000);
        wr_reg(ADDR_PROFILE1, 16'hA5C3);
        rd_chk(ADDR_PROFILE1, 16'hA5C3);
        check(profile, 16'hA5C3, "profile word");
        check({spread, tach_ol, tach_div, cyc_adj, r_shift, r_value}, 16'hA5C3, "profile fields");
        wr_reg(ADDR_ACCESS_CTRL, 16'h0000);
        check(profile, 16'h0000, "shadow off");
    endtask : test_profile

    task automatic test_single;
        nvsac_host_model_i.gap_cycles = 2;
        nvsac_host_model_i.set_inhibit(1'b1);
        nvsac_host_model_i.unlock();
        wr_reg(ADDR_TARGET, 16'h0091);
        rd_chk(ADDR_TARGET, 16'h0091);
        wr_reg(ADDR_WDATA, 16'h1234);
        wr_reg(ADDR_ACCESS_CTRL, 16'h0005);
        rd_chk(ADDR_READY, 16'h0000);
        wait_ready();
        rd_chk(ADDR_ACCESS_CTRL, 16'h0004);
        wr_reg(ADDR_ACCESS_CTRL, 16'h0001);
        wait_ready();
        rd_chk(ADDR_RDATA, 16'h1234);
        nvsac_host_model_i.gap_cycles = 0;
    endtask : test_single

    task automatic test_reload_bulk;
        wr_reg(ADDR_ACCESS_CTRL, 16'h1000);
        wr_reg(8'h91, 16'h5555);
        rd_chk(8'h91, 16'h5555);
        wr_reg(ADDR_ACCESS_CTRL, 16'h1104);
        repeat (2) @(negedge clock_i);
        wait_ready();
        rd_chk(8'h91, 16'h1234);
        rd_chk(ADDR_ACCESS_CTRL, 16'h1004);
        wr_reg(8'h92, 16'h0F0F);
        wr_reg(ADDR_ACCESS_CTRL, 16'h1006);
        repeat (2) @(negedge clock_i);
        wait_ready();
        wr_reg(8'h92, 16'h0000);
        wr_reg(ADDR_ACCESS_CTRL, 16'h1002);
        repeat (2) @(negedge clock_i);
        wait_ready();
        rd_chk(8'h92, 16'h0F0F);
        wr_reg(8'h92, 16'h0000);
        wr_reg(ADDR_ACCESS_CTRL, 16'h1003);
        rd_chk(ADDR_READY, 16'h0001);
        rd_chk(8'h92, 16'h0000);
    endtask : test_reload_bulk

    // ----------------------------------------
    // clock, reset and sequence
    // ----------------------------------------
    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    initial
    begin
        arst_n_i = 1'b0;
        repeat (12) @(negedge clock_i);
        arst_n_i = 1'b1;
        test_reset();
        test_holes();
        test_inhibit();
        test_profile();
        test_single();
        test_reload_bulk();
        end_sim();
    end
endmodule : test_nvsac_top
